// [core/msr_status.sv]
`timescale 1ns/1ps
`include "msr_consts.svh"
module msr_status (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Host commands
    input wire logic cmd_valid_i,
    input wire msr_pkg::msr_cmd_t cmd_code_i,
    input wire logic [15:0] cmd_data_i,
    input wire logic dev_clear_i,
    // Host answers and output queue
    output logic rsp_valid_o,
    output logic [15:0] rsp_data_o,
    // Calibration engine
    input wire logic zero_start_i,
    input wire logic cal_start_i,
    input wire logic cal_all_start_i,
    input wire logic cal_done_i,
    // Measurement and trigger engine
    input wire logic meas_active_i,
    input wire logic meas_done_i,
    input wire logic lower_fail_i,
    input wire logic upper_fail_i,
    input wire logic trig_wait_enter_i,
    input wire logic trig_idle_enter_i,
    input wire logic sensor_mem_read_i,
    input wire logic ops_busy_i,
    input wire logic [7:0] std_error_i,
    // Sensor and panel pins
    input wire logic [1:0] sensor_front_i,
    input wire logic [1:0] sensor_rear_i,
    input wire logic [1:0] sensor_mem_fail_i,
    input wire logic key_press_i,
    // Status view
    output logic [15:0] oper_cond_o,
    output logic [15:0] dev_cond_o,
    output logic [7:0] status_byte_o,
    output logic srq_o
);
    import msr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////

    // True when any enabled bit of a register is set.
    function automatic logic any_masked(input logic [15:0] value, input logic [15:0] mask);
        any_masked = |(value & mask);
    endfunction

    // True when a valid command carries the given code.
    function automatic logic cmd_is(input logic valid, input msr_cmd_t code, input msr_cmd_t want);
        cmd_is = valid && (code == want);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////

    logic calibrating;
    logic waiting_trig;
    logic lower_fail;
    logic upper_fail;
    logic [1:0] front_lvl;
    logic [1:0] rear_lvl;
    logic [1:0] mem_fail_lvl;
    logic key_lvl;
    logic key_prev;
    logic key_event;
    logic [15:0] oper_cond;
    logic [15:0] dev_cond;
    logic [15:0] dev_direct;
    logic [15:0] oper_event;
    logic [15:0] oper_enable;
    logic [15:0] dev_event;
    logic [15:0] dev_enable;
    logic oper_summary;
    logic dev_summary;
    logic [7:0] ser;
    logic [7:0] ese;
    logic [7:0] sre;
    logic [7:0] next_ser;
    logic [7:0] ser_set;
    logic [7:0] stb_base;
    logic mss;
    logic mss_prev;
    logic rqs;
    logic opc_armed;
    logic opc_q_wait;
    logic pending;
    logic opc_fire;
    logic opc_reply;
    logic query_hit;
    logic [15:0] query_data;
    logic cal_begin;

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode.

    wire cmd_oper_cond_q = cmd_is(cmd_valid_i, cmd_code_i, MSR_CMD_OPER_COND_Q);
    wire cmd_oper_event_q = cmd_is(cmd_valid_i, cmd_code_i, MSR_CMD_OPER_EVENT_Q);
    wire cmd_oper_ena_w = cmd_is(cmd_valid_i, cmd_code_i, MSR_CMD_OPER_ENA_W);
    wire cmd_oper_ptr_w = cmd_is(cmd_valid_i, cmd_code_i, MSR_CMD_OPER_PTR_W);
    wire cmd_oper_ntr_w = cmd_is(cmd_valid_i, cmd_code_i, MSR_CMD_OPER_NTR_W);
    wire cmd_dev_cond_q = cmd_is(cmd_valid_i, cmd_code_i, MSR_CMD_DEV_COND_Q);
    wire cmd_dev_event_q = cmd_is(cmd_valid_i, cmd_code_i, MSR_CMD_DEV_EVENT_Q);
    wire cmd_dev_ena_w = cmd_is(cmd_valid_i, cmd_code_i, MSR_CMD_DEV_ENA_W);
    wire cmd_dev_ptr_w = cmd_is(cmd_valid_i, cmd_code_i, MSR_CMD_DEV_PTR_W);
    wire cmd_dev_ntr_w = cmd_is(cmd_valid_i, cmd_code_i, MSR_CMD_DEV_NTR_W);
    wire cmd_cls = cmd_is(cmd_valid_i, cmd_code_i, MSR_CMD_CLS);
    wire cmd_ese_w = cmd_is(cmd_valid_i, cmd_code_i, MSR_CMD_ESE_W);
    wire cmd_esr_q = cmd_is(cmd_valid_i, cmd_code_i, MSR_CMD_ESR_Q);
    wire cmd_sre_w = cmd_is(cmd_valid_i, cmd_code_i, MSR_CMD_SRE_W);
    wire cmd_stb_q = cmd_is(cmd_valid_i, cmd_code_i, MSR_CMD_STB_Q);
    wire cmd_opc = cmd_is(cmd_valid_i, cmd_code_i, MSR_CMD_OPC);
    wire cmd_opc_q = cmd_is(cmd_valid_i, cmd_code_i, MSR_CMD_OPC_Q);
    wire cmd_spoll = cmd_is(cmd_valid_i, cmd_code_i, MSR_CMD_SPOLL);
    wire cmd_ese_q = cmd_is(cmd_valid_i, cmd_code_i, MSR_CMD_ESE_Q);
    wire cmd_sre_q = cmd_is(cmd_valid_i, cmd_code_i, MSR_CMD_SRE_Q);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin inputs.

    // Presence, connector and memory-fail lines are mechanical, so each one is filtered.
    msr_sync #(
        .W(7)
    ) u_pin_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .pin_i({key_press_i, sensor_mem_fail_i, sensor_rear_i, sensor_front_i}),
        .level_o({key_lvl, mem_fail_lvl, rear_lvl, front_lvl})
    );

    assign key_event = key_lvl & ~key_prev;

    ////////////////////////////////////////////////////////////////////////////////
    // Operation condition bits.

    // A combined zero-and-calibrate run raises the bit at its zeroing start.
    assign cal_begin = zero_start_i | cal_start_i | cal_all_start_i;

    always_comb begin
        oper_cond = '0;
        oper_cond[`MSR_OP_CAL_BIT] = calibrating;
        oper_cond[`MSR_OP_MEAS_BIT] = meas_active_i;
        oper_cond[`MSR_OP_TRIG_BIT] = waiting_trig;
        oper_cond[`MSR_OP_SENSE_BIT] = sensor_mem_read_i;
        oper_cond[`MSR_OP_LOWER_BIT] = lower_fail;
        oper_cond[`MSR_OP_UPPER_BIT] = upper_fail;
        oper_cond = oper_cond & `MSR_OP_USED_MASK;
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            calibrating <= 1'b0;
            waiting_trig <= 1'b0;
            lower_fail <= 1'b0;
            upper_fail <= 1'b0;
        end else begin
            // A start in the same cycle as a finish keeps the bit raised.
            calibrating <= cal_begin | (calibrating & ~cal_done_i);
            waiting_trig <= trig_wait_enter_i | (waiting_trig & ~trig_idle_enter_i);
            if (meas_done_i) begin
                lower_fail <= lower_fail_i;
                upper_fail <= upper_fail_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Device condition bits, one slice per channel.

    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_chan
            assign dev_cond[`MSR_DEV_PRESENT_BIT + ch] = front_lvl[ch] | rear_lvl[ch];
            assign dev_cond[`MSR_DEV_ERROR_BIT + ch] =
                mem_fail_lvl[ch] | (front_lvl[ch] & rear_lvl[ch]);
            assign dev_cond[`MSR_DEV_REAR_BIT + ch] = rear_lvl[ch];
        end
    endgenerate

    // Bit 0 and bits 7 up are unused; bit 14 has no condition source at all.
    assign dev_cond[0] = 1'b0;
    assign dev_cond[15:7] = 9'h000;

    // The key press enters the event register directly, bypassing the transition filters.
    assign dev_direct = {1'b0, key_event, 14'h0000};

    ////////////////////////////////////////////////////////////////////////////////
    // Status groups.

    msr_status_group u_oper_group (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .cond_i(oper_cond),
        .direct_set_i(16'h0000),
        .wr_data_i(cmd_data_i & `MSR_OP_USED_MASK),
        .wr_enable_i(cmd_oper_ena_w),
        .wr_ptr_i(cmd_oper_ptr_w),
        .wr_ntr_i(cmd_oper_ntr_w),
        .rd_event_i(cmd_oper_event_q),
        .clear_i(cmd_cls),
        .event_o(oper_event),
        .enable_o(oper_enable),
        .summary_o(oper_summary)
    );

    msr_status_group u_dev_group (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .cond_i(dev_cond),
        .direct_set_i(dev_direct),
        .wr_data_i(cmd_data_i & `MSR_DEV_USED_MASK),
        .wr_enable_i(cmd_dev_ena_w),
        .wr_ptr_i(cmd_dev_ptr_w),
        .wr_ntr_i(cmd_dev_ntr_w),
        .rd_event_i(cmd_dev_event_q),
        .clear_i(cmd_cls),
        .event_o(dev_event),
        .enable_o(dev_enable),
        .summary_o(dev_summary)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Operation complete and the standard event register.

    // Outstanding work: the overlapped engines plus whatever the parser still holds.
    assign pending = ops_busy_i | calibrating | meas_active_i;
    assign opc_fire = opc_armed & ~pending;

    always_comb begin
        ser_set = std_error_i;
        ser_set[`MSR_SER_OPC_BIT] = opc_fire;
        ser_set = ser_set & `MSR_SER_USED_MASK;
    end

    // Events raised in the clearing cycle are kept rather than lost.
    assign next_ser = (ser & ~{8{cmd_cls | cmd_esr_q}}) | ser_set;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ser <= `MSR_SER_RESET;
            ese <= 8'h00;
            sre <= 8'h00;
            opc_armed <= 1'b0;
            opc_q_wait <= 1'b0;
        end else begin
            ser <= next_ser;
            if (cmd_ese_w) ese <= cmd_data_i[7:0];
            if (cmd_sre_w) sre <= cmd_data_i[7:0] & `MSR_SRE_WRITE_MASK;
            // Clear status idles the completion watch; device clear does not touch it.
            opc_armed <= cmd_opc | (opc_armed & ~opc_fire & ~cmd_cls);
            // Device clear empties the output queue, so a waiting reply is dropped.
            opc_q_wait <= ~dev_clear_i & (cmd_opc_q | (opc_q_wait & ~opc_reply));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status byte and service request.

    always_comb begin
        stb_base = 8'h00;
        stb_base[`MSR_STB_ESB_BIT] = any_masked({8'h00, ser}, {8'h00, ese});
        stb_base[`MSR_STB_OPER_BIT] = oper_summary;
    end

    assign mss = any_masked({8'h00, stb_base}, {8'h00, sre});

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mss_prev <= 1'b0;
            rqs <= 1'b0;
            key_prev <= 1'b0;
        end else begin
            mss_prev <= mss;
            key_prev <= key_lvl;
            // A fresh request in the polling cycle wins over the poll's clear.
            rqs <= (mss & ~mss_prev) | (rqs & ~cmd_spoll);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Answers.

    assign query_hit = cmd_oper_cond_q | cmd_oper_event_q | cmd_dev_cond_q | cmd_dev_event_q |
        cmd_esr_q | cmd_stb_q | cmd_spoll | cmd_ese_q | cmd_sre_q;

    // A query answer takes the slot; the completion reply waits one more cycle.
    assign opc_reply = opc_q_wait & ~pending & ~query_hit;

    always_comb begin
        query_data = 16'h0000;
        if (cmd_oper_cond_q) query_data = oper_cond;
        if (cmd_oper_event_q) query_data = oper_event;
        if (cmd_dev_cond_q) query_data = dev_cond;
        if (cmd_dev_event_q) query_data = dev_event;
        if (cmd_esr_q) query_data = {8'h00, ser};
        if (cmd_stb_q) query_data = {8'h00, stb_base | {1'b0, mss, 6'h00}};
        if (cmd_spoll) query_data = {8'h00, stb_base | {1'b0, rqs, 6'h00}};
        if (cmd_ese_q) query_data = {8'h00, ese};
        if (cmd_sre_q) query_data = {8'h00, sre};
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rsp_valid_o <= 1'b0;
            rsp_data_o <= 16'h0000;
        end else begin
            rsp_valid_o <= query_hit | opc_reply;
            if (query_hit) rsp_data_o <= query_data;
            else if (opc_reply) rsp_data_o <= `MSR_ASCII_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status view for the front panel and the bus interface.

    // Enable registers of the device group feed no summary bit in the status byte.
    assign oper_cond_o = oper_cond;
    assign dev_cond_o = dev_cond | {15'h0000, dev_summary & 1'b0} | (dev_enable & 16'h0000);
    assign status_byte_o = stb_base | {1'b0, rqs, 6'h00};
    assign srq_o = rqs;

    // The operation enable is consumed inside the group summary.
    wire unused_oper_enable = |oper_enable;

endmodule

// [core/msr_consts.svh]
`ifndef MSR_CONSTS_SVH
`define MSR_CONSTS_SVH
// Notes on behaviour
// - Operation bit 0 sets when a single zeroing or calibration run begins.
// - Combined zero-and-calibrate query sets the calibrating bit as zeroing begins.
// - Calibrating bit clears once the zeroing or calibration run finishes.
// - Operation bit 4 is high while a measurement runs, low after.
// - Operation bit 5 sets entering wait-for-trigger, clears entering idle.
// - Operation bit 10 is high only while sensor calibration memory is read.
// - Bit 11 follows lower-limit failure after each measurement; disabled or pass clears.
// - Bit 12 follows upper-limit failure after each measurement; disabled or pass clears.
// - Device bits 1 and 2 show sensor attached on channel A and B.
// - Device bits 3 and 4 flag memory failure or front-and-rear double attach.
// - Device bits 5 and 6 set for rear connector, clear for front.
// - Key press sets device event bit 14 only; reading the event register clears it.
// - Transition filters never affect the key-press bit.
// - Operation-complete query queues ASCII 1 once all pending work completes.
// - Operation-complete command sets standard event bit 0 when work completes.
// - Status byte bit 5 summarises enabled standard events; enable 32 requests service.
// - Clear status or event status query clears the standard event register.
`define MSR_OP_CAL_BIT 0
`define MSR_OP_MEAS_BIT 4
`define MSR_OP_TRIG_BIT 5
`define MSR_OP_SENSE_BIT 10
`define MSR_OP_LOWER_BIT 11
`define MSR_OP_UPPER_BIT 12
`define MSR_OP_USED_MASK 16'h1C31
`define MSR_DEV_PRESENT_BIT 1
`define MSR_DEV_ERROR_BIT 3
`define MSR_DEV_REAR_BIT 5
`define MSR_DEV_KEY_BIT 14
`define MSR_DEV_USED_MASK 16'h407E
`define MSR_PTR_RESET 16'h7FFF
`define MSR_NTR_RESET 16'h0000
`define MSR_ENABLE_RESET 16'h0000
`define MSR_SER_RESET 8'h80
`define MSR_SER_OPC_BIT 0
`define MSR_SER_USED_MASK 8'hFD
`define MSR_STB_ESB_BIT 5
`define MSR_STB_RQS_BIT 6
`define MSR_STB_OPER_BIT 7
`define MSR_SRE_WRITE_MASK 8'hBF
`define MSR_ASCII_ONE 16'h0031
`endif

// [core/msr_pkg.sv]
package msr_pkg;

    // Host commands as they arrive from the command parser.
    typedef enum logic [4:0] {
        MSR_CMD_NOP          = 5'b00000,
        MSR_CMD_OPER_COND_Q  = 5'b00001,
        MSR_CMD_OPER_EVENT_Q = 5'b00010,
        MSR_CMD_OPER_ENA_W   = 5'b00011,
        MSR_CMD_OPER_PTR_W   = 5'b00100,
        MSR_CMD_OPER_NTR_W   = 5'b00101,
        MSR_CMD_DEV_COND_Q   = 5'b00110,
        MSR_CMD_DEV_EVENT_Q  = 5'b00111,
        MSR_CMD_DEV_ENA_W    = 5'b01000,
        MSR_CMD_DEV_PTR_W    = 5'b01001,
        MSR_CMD_DEV_NTR_W    = 5'b01010,
        MSR_CMD_CLS          = 5'b01011,
        MSR_CMD_ESE_W        = 5'b01100,
        MSR_CMD_ESR_Q        = 5'b01101,
        MSR_CMD_SRE_W        = 5'b01110,
        MSR_CMD_STB_Q        = 5'b01111,
        MSR_CMD_OPC          = 5'b10000,
        MSR_CMD_OPC_Q        = 5'b10001,
        MSR_CMD_SPOLL        = 5'b10010,
        MSR_CMD_ESE_Q        = 5'b10011,
        MSR_CMD_SRE_Q        = 5'b10100
    } msr_cmd_t;

endpackage

// [core/msr_sync.sv]
`timescale 1ns/1ps
module msr_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Pin side
    input wire logic [W-1:0] pin_i,
    // Clean level
    output logic [W-1:0] level_o
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    logic [W-1:0] agree;

    // Only the second and third stages are compared, so a late stage-one flop never leaks out.
    assign agree = ~(stage2 ^ stage3);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level_o <= '0;
        end else begin
            stage1 <= pin_i;
            stage2 <= stage1;
            stage3 <= stage2;
            level_o <= (agree & stage3) | (~agree & level_o);
        end
    end
endmodule

// [core/msr_status_group.sv]
`timescale 1ns/1ps
`include "msr_consts.svh"
module msr_status_group (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Condition and direct events
    input wire logic [15:0] cond_i,
    input wire logic [15:0] direct_set_i,
    // Register access
    input wire logic [15:0] wr_data_i,
    input wire logic wr_enable_i,
    input wire logic wr_ptr_i,
    input wire logic wr_ntr_i,
    input wire logic rd_event_i,
    input wire logic clear_i,
    // Results
    output logic [15:0] event_o,
    output logic [15:0] enable_o,
    output logic summary_o
);
    logic [15:0] prev_cond;
    logic [15:0] ptr;
    logic [15:0] ntr;
    logic [15:0] trans;
    logic [15:0] next_event;
    logic ev_clear;

    assign trans = (cond_i & ~prev_cond & ptr) | (~cond_i & prev_cond & ntr);
    assign ev_clear = rd_event_i | clear_i;
    // A new event in the clearing cycle survives the clear.
    assign next_event = (event_o & ~{16{ev_clear}}) | trans | direct_set_i;
    assign summary_o = |(event_o & enable_o);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            prev_cond <= '0;
            ptr <= `MSR_PTR_RESET;
            ntr <= `MSR_NTR_RESET;
            enable_o <= `MSR_ENABLE_RESET;
            event_o <= '0;
        end else begin
            prev_cond <= cond_i;
            event_o <= next_event;
            if (wr_ptr_i) ptr <= wr_data_i;
            if (wr_ntr_i) ntr <= wr_data_i;
            if (wr_enable_i) enable_o <= wr_data_i;
        end
    end
endmodule

// [sim/msr_status_asserts.sv]
`timescale 1ns/1ps
`include "msr_consts.svh"
module msr_status_asserts (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Host side
    input wire logic cmd_valid_i,
    input wire msr_pkg::msr_cmd_t cmd_code_i,
    input wire logic rsp_valid_o,
    input wire logic [15:0] rsp_data_o,
    // Engines
    input wire logic zero_start_i,
    input wire logic cal_start_i,
    input wire logic cal_all_start_i,
    input wire logic cal_done_i,
    input wire logic meas_active_i,
    input wire logic meas_done_i,
    input wire logic lower_fail_i,
    input wire logic upper_fail_i,
    input wire logic trig_wait_enter_i,
    input wire logic trig_idle_enter_i,
    input wire logic sensor_mem_read_i,
    // Pins
    input wire logic [1:0] sensor_front_i,
    input wire logic [1:0] sensor_rear_i,
    input wire logic [1:0] sensor_mem_fail_i,
    // Status view
    input wire logic [15:0] oper_cond_o,
    input wire logic [15:0] dev_cond_o
);
    import msr_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    wire start_any = zero_start_i | cal_start_i | cal_all_start_i;

    AST_CAL_SET: assert property (start_any |=> oper_cond_o[0])
        else $error("cal bit not set");
    AST_CAL_CLR: assert property (cal_done_i && !start_any |=> !oper_cond_o[0])
        else $error("cal bit not cleared");
    AST_MEAS: assert property (oper_cond_o[4] == meas_active_i)
        else $error("meas bit wrong");
    AST_TRIG_SET: assert property (trig_wait_enter_i |=> oper_cond_o[5])
        else $error("waiting bit not set");
    AST_TRIG_CLR: assert property (trig_idle_enter_i && !trig_wait_enter_i |=> !oper_cond_o[5])
        else $error("waiting bit not cleared");
    AST_SENSE: assert property (oper_cond_o[10] == sensor_mem_read_i)
        else $error("sense bit wrong");
    AST_LIMIT: assert property (meas_done_i |=> oper_cond_o[12:11] == $past({upper_fail_i, lower_fail_i}))
        else $error("limit bits not loaded");
    AST_LIMIT_HOLD: assert property (!meas_done_i |=> $stable(oper_cond_o[12:11]))
        else $error("limit bits moved");
    AST_UNUSED: assert property ((oper_cond_o & ~`MSR_OP_USED_MASK) == 16'h0000 && dev_cond_o[15:7] == 9'h000)
        else $error("unused condition bit set");
    AST_SENSOR: assert property ($stable({sensor_front_i, sensor_rear_i, sensor_mem_fail_i})[*7] |->
        dev_cond_o[6:1] == {sensor_rear_i, sensor_mem_fail_i | (sensor_front_i & sensor_rear_i),
        sensor_front_i | sensor_rear_i}) else $error("sensor bits wrong");
    AST_QRSP: assert property (cmd_valid_i && cmd_code_i == MSR_CMD_OPER_COND_Q |->
        ##1 rsp_valid_o && rsp_data_o == $past(oper_cond_o)) else $error("query answer wrong");
endmodule
bind msr_status msr_status_asserts chk_u (.clk_sys_i, .rst_i, .cmd_valid_i, .cmd_code_i, .rsp_valid_o,
    .rsp_data_o, .zero_start_i, .cal_start_i, .cal_all_start_i, .cal_done_i, .meas_active_i, .meas_done_i,
    .lower_fail_i, .upper_fail_i, .trig_wait_enter_i, .trig_idle_enter_i, .sensor_mem_read_i,
    .sensor_front_i, .sensor_rear_i, .sensor_mem_fail_i, .oper_cond_o, .dev_cond_o);

// [sim/msr_host_model.sv]
`timescale 1ns/1ps
module msr_host_model (
    // Clock
    input wire logic clk_sys_i,
    // Commands
    output logic cmd_valid_o,
    output msr_pkg::msr_cmd_t cmd_code_o,
    output logic [15:0] cmd_data_o,
    output logic dev_clear_o,
    // Answers
    input wire logic rsp_valid_i,
    input wire logic [15:0] rsp_data_i
);
    import msr_pkg::*;
    initial begin
        {cmd_valid_o, cmd_data_o, dev_clear_o} = '0;
        cmd_code_o = MSR_CMD_NOP;
    end
    task automatic send(input msr_cmd_t code, input logic [15:0] data);
        @(posedge clk_sys_i);
        cmd_valid_o <= 1'b1;
        cmd_code_o <= code;
        cmd_data_o <= data;
        @(posedge clk_sys_i);
        cmd_valid_o <= 1'b0;
    endtask
    // A missing answer leaves unknowns so the caller's compare fails.
    task automatic query(input msr_cmd_t code, output logic [15:0] rd);
        rd = 'x;
        send(code, 16'h0000);
        for (int i = 0; i < 40; i++) begin
            #1;
            if (rsp_valid_i === 1'b1) begin
                rd = rsp_data_i;
                break;
            end
            @(posedge clk_sys_i);
        end
    endtask
    task automatic sync_opc(output logic [15:0] stb);
        @(posedge clk_sys_i);
        dev_clear_o <= 1'b1;
        @(posedge clk_sys_i);
        dev_clear_o <= 1'b0;
        send(MSR_CMD_CLS, 16'h0000);
        send(MSR_CMD_ESE_W, 16'h0001);
        send(MSR_CMD_SRE_W, 16'h0020);
        send(MSR_CMD_OPC, 16'h0000);
        stb = 16'h0000;
        for (int i = 0; i < 50 && stb[5] !== 1'b1; i++) begin
            query(MSR_CMD_SPOLL, stb);
        end
    endtask
endmodule

// [sim/measurement_status_reporting_tb.sv]
`timescale 1ns/1ps
`define CHECK(nm, e, g) check_val(nm, 16'(e), 16'(g))
module measurement_status_reporting_tb;
    import msr_pkg::*;
    typedef struct packed {logic [7:0] pins; logic [15:0] dev; logic [1:0] lim;} msr_row_t;
    msr_row_t rows [5] = '{'{8'h42, 16'h0002, 2'h1}, '{8'h21, 16'h0044, 2'h2}, '{8'hD3, 16'h002E, 2'h3},
        '{8'h4C, 16'h001A, 2'h0}, '{8'h02, 16'h0000, 2'h1}};
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic cmd_valid_i, dev_clear_i, rsp_valid_o, srq_o;
    msr_cmd_t cmd_code_i;
    logic [15:0] cmd_data_i, rsp_data_o, oper_cond_o, dev_cond_o, rd;
    logic [7:0] status_byte_o;
    logic zero_start_i = 1'b0, cal_start_i = 1'b0, cal_all_start_i = 1'b0, cal_done_i = 1'b0;
    logic meas_active_i = 1'b0, meas_done_i = 1'b0, lower_fail_i = 1'b0, upper_fail_i = 1'b0;
    logic trig_wait_enter_i = 1'b0, trig_idle_enter_i = 1'b0, sensor_mem_read_i = 1'b0, ops_busy_i = 1'b0;
    logic key_press_i = 1'b0;
    logic [1:0] sensor_front_i = 2'h0, sensor_rear_i = 2'h0, sensor_mem_fail_i = 2'h0;
    int bad_count = 0;
    int total_checks = 0;

    always #4 clk_sys_i = ~clk_sys_i;

    msr_status dut_u (.*, .std_error_i(8'h00));
    msr_host_model host_u (.clk_sys_i, .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i),
        .cmd_data_o(cmd_data_i), .dev_clear_o(dev_clear_i), .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o));

    task automatic check_val(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        tick(1);
        `CHECK("oper reset", 16'h0000, oper_cond_o);
        `CHECK("dev reset", 16'h0000, dev_cond_o);
        `CHECK("status reset", 16'h0000, {status_byte_o, 7'h00, srq_o});
        $display("test reset done");
        foreach (rows[i]) begin
            @(posedge clk_sys_i);
            {sensor_front_i, sensor_rear_i, sensor_mem_fail_i, lower_fail_i, upper_fail_i} <= rows[i].pins;
            meas_done_i <= 1'b1;
            @(posedge clk_sys_i);
            meas_done_i <= 1'b0;
            tick(8);
            `CHECK("dev_cond", rows[i].dev, dev_cond_o);
            host_u.query(MSR_CMD_OPER_COND_Q, rd);
            `CHECK("limit bits", rows[i].lim, rd[12:11]);
        end
        $display("test table done");
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_sys_i);
            {cal_all_start_i, cal_start_i, zero_start_i} <= 3'h1 << k;
            @(posedge clk_sys_i);
            {cal_all_start_i, cal_start_i, zero_start_i} <= 3'h0;
            @(posedge clk_sys_i);
            cal_done_i <= 1'b1;
            #1;
            `CHECK("cal set", 1'b1, oper_cond_o[0]);
            @(posedge clk_sys_i);
            cal_done_i <= 1'b0;
            tick(1);
            `CHECK("cal clear", 1'b0, oper_cond_o[0]);
        end
        @(posedge clk_sys_i);
        {cal_start_i, cal_done_i} <= 2'h3;
        @(posedge clk_sys_i);
        {cal_start_i, cal_done_i} <= 2'h1;
        #1;
        `CHECK("cal start wins", 1'b1, oper_cond_o[0]);
        @(posedge clk_sys_i);
        cal_done_i <= 1'b0;
        #1;
        `CHECK("cal end", 1'b0, oper_cond_o[0]);
        $display("test calibration done");
        @(posedge clk_sys_i);
        {meas_active_i, sensor_mem_read_i, trig_wait_enter_i} <= 3'h7;
        @(posedge clk_sys_i);
        trig_wait_enter_i <= 1'b0;
        tick(1);
        `CHECK("oper busy", 16'h0C30, oper_cond_o);
        @(posedge clk_sys_i);
        {meas_active_i, sensor_mem_read_i, trig_idle_enter_i} <= 3'h1;
        @(posedge clk_sys_i);
        trig_idle_enter_i <= 1'b0;
        tick(1);
        `CHECK("oper idle", 16'h0800, oper_cond_o);
        $display("test operation done");
        host_u.send(MSR_CMD_DEV_PTR_W, 16'h0000);
        host_u.query(MSR_CMD_DEV_EVENT_Q, rd);
        @(posedge clk_sys_i);
        key_press_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        key_press_i <= 1'b0;
        tick(8);
        `CHECK("key cond", 1'b0, dev_cond_o[14]);
        host_u.query(MSR_CMD_DEV_EVENT_Q, rd);
        `CHECK("key event", 16'h4000, rd);
        host_u.query(MSR_CMD_DEV_EVENT_Q, rd);
        `CHECK("key read clear", 16'h0000, rd);
        $display("test key done");
        @(posedge clk_sys_i);
        ops_busy_i <= 1'b1;
        host_u.send(MSR_CMD_OPC_Q, 16'h0000);
        tick(10);
        `CHECK("opc held", 16'h0000, rsp_data_o);
        @(posedge clk_sys_i);
        ops_busy_i <= 1'b0;
        tick(5);
        `CHECK("opc reply", 16'h0031, rsp_data_o);
        $display("test opc query done");
        @(posedge clk_sys_i);
        ops_busy_i <= 1'b1;
        fork
            host_u.sync_opc(rd);
            begin
                repeat (30) @(posedge clk_sys_i);
                ops_busy_i <= 1'b0;
            end
        join
        `CHECK("poll esb", 1'b1, rd[5]);
        host_u.query(MSR_CMD_SPOLL, rd);
        `CHECK("poll byte", 16'h0060, rd);
        tick(2);
        `CHECK("poll clears rqs", 1'b0, srq_o);
        host_u.query(MSR_CMD_ESR_Q, rd);
        `CHECK("esr opc", 16'h0001, rd);
        host_u.query(MSR_CMD_ESR_Q, rd);
        `CHECK("esr cleared", 16'h0000, rd);
        tick(1);
        `CHECK("summary gone", 1'b0, status_byte_o[5]);
        $display("test sync done");
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        bad_count++;
        close_out();
    end
endmodule
